/* deep_sleep_pkg.sv */
// Shared constants for the deep sleep controller: register map, fields, resets and timing.
package deep_sleep_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [11:0] IDX_WAKE_STATUS_LOW = 12'hF4A;
  localparam logic [11:0] IDX_WAKE_STATUS_HIGH = 12'hF4B;
  localparam logic [11:0] IDX_SLEEP_LOW_CONTROL = 12'hF4C;
  localparam logic [11:0] IDX_SLEEP_HIGH_CONTROL = 12'hF4D;
  localparam logic [11:0] IDX_PERSISTENT_SCRATCH_ZERO = 12'hF4E;
  localparam logic [11:0] IDX_WATCHDOG_CONTROL_REG = 12'hF50;
  localparam logic [11:0] IDX_SLEEP_CONFIG = 12'hF51;
  localparam logic [11:0] IDX_THIRD_CONFIG_LOW_BYTE = 12'hF52;
  localparam int ADDR_WIDTH = 14;

  // Field positions.
  localparam int POS_FAULT = 7;
  localparam int POS_SLOW_WAKE = 5;
  localparam int POS_WATCHDOG_WAKE = 4;
  localparam int POS_CALENDAR_WAKE = 3;
  localparam int POS_MCLR_WAKE = 2;
  localparam int POS_POWER_ON = 0;
  localparam int POS_EXT_INT_WAKE = 0;
  localparam int POS_LOW_POWER_SLEEP_ENABLE = 7;
  localparam int POS_SLOW_DISCHARGE_MODULE_ENABLE = 1;
  localparam int POS_CALENDAR_WAKE_DISABLE = 0;
  localparam int POS_SLOW_DISCHARGE_WAKE_DISABLE = 2;
  localparam int POS_SLEEP_BROWNOUT_EVENT = 1;
  localparam int POS_PIN_RELEASE = 0;
  localparam int POS_REGULATOR_SLEEP = 7;
  localparam int POS_SLEEP_EXIT_FLAG = 3;
  localparam int POS_WATCHDOG_ENABLE = 0;
  localparam int POS_WATCHDOG_CLOCK_SELECT = 1;
  localparam int POS_POSTSCALE_LSB = 2;
  localparam int POS_BROWNOUT_ENABLE = 6;
  localparam int POS_CALENDAR_CLOCK_SELECT = 1;

  // Reset values.
  localparam logic [7:0] RST_WAKE_STATUS_LOW = 8'h01;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_SLEEP_CONFIG = 8'h00;

  // Timing.
  localparam int CLK_MHZ = 250;
  localparam int CLKS_PER_INSTR = 4;
  localparam int SLEEP_ENABLE_LIFE_INSTR = 2;
  localparam int POR_HOLD_NS = 1000;
  localparam int POR_HOLD_CYC = (POR_HOLD_NS * CLK_MHZ + 999) / 1000;
  // Watchdog: shortest period about 2.1 ms, longest about 25.7 days, on a 31 kHz tick.
  localparam real WATCHDOG_MIN_MS = 2.1;
  localparam real WATCHDOG_MAX_DAYS = 25.7;
  localparam int WATCHDOG_BASE_SHIFT = 6;
  localparam int WATCHDOG_STEP_SHIFT = 2;
  localparam int WATCHDOG_CNT_W = WATCHDOG_BASE_SHIFT + 15 * WATCHDOG_STEP_SHIFT + 1;

  // Index of each synchronised pin input.
  localparam int SY_MCLR_N = 0;
  localparam int SY_CAL_ALARM = 1;
  localparam int SY_EXT_INT = 2;
  localparam int SY_SLOW_WAKE = 3;
  localparam int SY_FAULT = 4;
  localparam int SY_ARM_LOW = 5;
  localparam int SY_TRIP_LOW = 6;
  localparam int SY_CORE_BOR = 7;
  localparam int SY_RC_TICK = 8;
  localparam int SY_TMR_TICK = 9;
  localparam int SY_W = 10;
  localparam logic [9:0] SY_RST = 10'h001;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ASLEEP = 2'b01,
    ST_WAKE_RESET = 2'b10
  } sleep_state_t;
endpackage : deep_sleep_pkg

/* deep_sleep_controller.sv */
// Deep sleep controller: entry, wake logging, watchdog, pin hold and persistent scratch.
`timescale 1ns/10ps
`default_nettype none
module deep_sleep_controller
  import deep_sleep_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sleep_instr_in,
  input wire logic [PIN_COUNT-1:0] pin_direction_bits_in,
  input wire logic [PIN_COUNT-1:0] pin_output_level_bits_in,
  input wire logic mclr_n_in,
  input wire logic calendar_alarm_in,
  input wire logic ext_int_in,
  input wire logic slow_discharge_wake_in,
  input wire logic sleep_fault_in,
  input wire logic supply_below_arm_in,
  input wire logic supply_below_trip_in,
  input wire logic core_brownout_in,
  input wire logic internal_rc_oscillator_in,
  input wire logic secondary_timer_oscillator_in,
  output logic [PIN_COUNT-1:0] pin_level_out,
  output logic [PIN_COUNT-1:0] pin_oe_n_out,
  output logic regulator_off_out,
  output logic conventional_sleep_out,
  output logic core_reset_out,
  output logic slow_discharge_module_on_out,
  output logic calendar_tick_out
);
  logic [SY_W-1:0] sync1_q;
  logic [SY_W-1:0] sync2_q;
  logic [SY_W-1:0] sync3_q;
  logic [SY_W-1:0] rise;
  sleep_state_t state_q;
  sleep_state_t state_d;
  logic [7:0] wake_low_q;
  logic wake_high_q;
  logic [7:0] low_ctrl_q;
  logic [7:0] high_ctrl_q;
  logic [7:0] scratch_q;
  logic [7:0] wdt_ctrl_q;
  logic [7:0] config_q;
  logic [7:0] config3_q;
  logic [31:0] prdata_q;
  logic [1:0] instr_div_q;
  logic [1:0] low_power_sleep_enable_age_q;
  logic [WATCHDOG_CNT_W-1:0] wdt_cnt_q;
  logic [WATCHDOG_CNT_W-1:0] wdt_limit;
  logic [15:0] por_cnt_q;
  logic [PIN_COUNT-1:0] held_dir_q;
  logic [PIN_COUNT-1:0] held_level_q;
  logic logged_q;
  logic instr_tick;
  logic wr_en;
  logic setup_phase;
  logic [11:0] idx;
  logic addr_ok;
  logic mapped;
  logic enter_deep;
  logic wdt_tick;
  logic wdt_timeout;
  logic cal_wake;
  logic slow_wake;
  logic fault_wake;
  logic mclr_wake;
  logic bor_trip;
  logic any_wake;
  logic wake_por;
  logic leave_sleep;

  // The first flop feeds only the second; edge detection uses the second and third.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_q <= SY_RST;
      sync2_q <= SY_RST;
      sync3_q <= SY_RST;
    end else begin
      sync1_q <= {secondary_timer_oscillator_in, internal_rc_oscillator_in, core_brownout_in,
                  supply_below_trip_in, supply_below_arm_in, sleep_fault_in,
                  slow_discharge_wake_in, ext_int_in, calendar_alarm_in, mclr_n_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign rise = sync2_q & ~sync3_q;

  // Instruction-cycle enable pulse.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      instr_div_q <= 2'h0;
    end else begin
      instr_div_q <= instr_div_q + 2'h1;
    end
  end
  assign instr_tick = (instr_div_q == 2'(CLKS_PER_INSTR - 1));

  // APB decode: zero wait states, read data captured in the setup cycle.
  assign idx = paddr_in[ADDR_WIDTH-1:2];
  assign addr_ok = (paddr_in[15:ADDR_WIDTH] == 2'h0) && (paddr_in[1:0] == 2'h0);
  always_comb begin
    mapped = 1'b0;
    case (idx)
      IDX_WAKE_STATUS_LOW, IDX_WAKE_STATUS_HIGH, IDX_SLEEP_LOW_CONTROL,
      IDX_SLEEP_HIGH_CONTROL, IDX_PERSISTENT_SCRATCH_ZERO, IDX_WATCHDOG_CONTROL_REG,
      IDX_SLEEP_CONFIG, IDX_THIRD_CONFIG_LOW_BYTE: mapped = addr_ok;
      default: mapped = 1'b0;
    endcase
  end
  assign setup_phase = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pwrite_in && mapped;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out = prdata_q;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_q <= 32'h0000_0000;
      if (addr_ok) begin
        case (idx)
          IDX_WAKE_STATUS_LOW: prdata_q[7:0] <= wake_low_q;
          IDX_WAKE_STATUS_HIGH: prdata_q[0] <= wake_high_q;
          IDX_SLEEP_LOW_CONTROL: prdata_q[7:0] <= low_ctrl_q;
          IDX_SLEEP_HIGH_CONTROL: prdata_q[7:0] <= high_ctrl_q;
          IDX_PERSISTENT_SCRATCH_ZERO: prdata_q[7:0] <= scratch_q;
          IDX_WATCHDOG_CONTROL_REG: prdata_q[7:0] <= wdt_ctrl_q;
          IDX_SLEEP_CONFIG: prdata_q[7:0] <= config_q;
          IDX_THIRD_CONFIG_LOW_BYTE: prdata_q[7:0] <= config3_q;
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Wake qualification while fully asleep.
  assign fault_wake = sync2_q[SY_FAULT];
  assign mclr_wake = !sync2_q[SY_MCLR_N];
  assign cal_wake = rise[SY_CAL_ALARM] && !high_ctrl_q[POS_CALENDAR_WAKE_DISABLE];
  assign slow_wake = rise[SY_SLOW_WAKE] && high_ctrl_q[POS_SLOW_DISCHARGE_MODULE_ENABLE]
                     && !low_ctrl_q[POS_SLOW_DISCHARGE_WAKE_DISABLE];
  assign bor_trip = config_q[POS_BROWNOUT_ENABLE] && sync2_q[SY_TRIP_LOW];
  assign any_wake = fault_wake || mclr_wake || cal_wake || wdt_timeout || slow_wake
                    || rise[SY_EXT_INT] || bor_trip;
  assign enter_deep = (state_q == ST_RUN) && sleep_instr_in
                      && high_ctrl_q[POS_LOW_POWER_SLEEP_ENABLE];
  assign conventional_sleep_out = (state_q == ST_RUN) && sleep_instr_in
                                  && !high_ctrl_q[POS_LOW_POWER_SLEEP_ENABLE];
  assign leave_sleep = (state_q == ST_ASLEEP) && any_wake;
  assign wake_por = (state_q == ST_WAKE_RESET) && (por_cnt_q == 16'(POR_HOLD_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (enter_deep) begin
          state_d = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (any_wake) begin
          state_d = ST_WAKE_RESET;
        end
      end
      ST_WAKE_RESET: begin
        if (wake_por) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Power-on reset hold after a wake.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      por_cnt_q <= 16'h0000;
    end else if (state_q == ST_WAKE_RESET) begin
      por_cnt_q <= por_cnt_q + 16'h0001;
    end else begin
      por_cnt_q <= 16'h0000;
    end
  end
  assign core_reset_out = (state_q == ST_WAKE_RESET);
  assign regulator_off_out = (state_q == ST_ASLEEP);

  // Sleep watchdog.
  assign wdt_tick = config_q[POS_WATCHDOG_CLOCK_SELECT] ? rise[SY_TMR_TICK]
                                                        : rise[SY_RC_TICK];
  assign wdt_limit = (WATCHDOG_CNT_W'(1) << (WATCHDOG_BASE_SHIFT + WATCHDOG_STEP_SHIFT
                     * int'(config_q[POS_POSTSCALE_LSB +: 4]))) - WATCHDOG_CNT_W'(1);
  assign wdt_timeout = (state_q == ST_ASLEEP) && config_q[POS_WATCHDOG_ENABLE]
                       && wdt_tick && (wdt_cnt_q == wdt_limit);
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wdt_cnt_q <= '0;
    end else if (enter_deep) begin
      wdt_cnt_q <= '0;
    end else if ((state_q == ST_ASLEEP) && config_q[POS_WATCHDOG_ENABLE] && wdt_tick) begin
      wdt_cnt_q <= wdt_cnt_q + WATCHDOG_CNT_W'(1);
    end
  end

  // Calendar tick keeps running in every state.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      calendar_tick_out <= 1'b0;
    end else begin
      calendar_tick_out <= config3_q[POS_CALENDAR_CLOCK_SELECT] ? rise[SY_TMR_TICK]
                                                                : rise[SY_RC_TICK];
    end
  end
  assign slow_discharge_module_on_out = (state_q == ST_ASLEEP)
                                        && high_ctrl_q[POS_SLOW_DISCHARGE_MODULE_ENABLE];

  // Sleep enable lifetime in instruction cycles.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_power_sleep_enable_age_q <= 2'h0;
    end else if (wr_en && (idx == IDX_SLEEP_HIGH_CONTROL)) begin
      low_power_sleep_enable_age_q <= 2'h0;
    end else if (high_ctrl_q[POS_LOW_POWER_SLEEP_ENABLE] && instr_tick) begin
      low_power_sleep_enable_age_q <= low_power_sleep_enable_age_q + 2'h1;
    end
  end

  // High control register; wake resets it.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      high_ctrl_q <= RST_CONTROL;
    end else if (wake_por || enter_deep) begin
      high_ctrl_q[POS_LOW_POWER_SLEEP_ENABLE] <= 1'b0;
      if (wake_por) begin
        high_ctrl_q <= RST_CONTROL;
      end
    end else if (wr_en && (idx == IDX_SLEEP_HIGH_CONTROL)) begin
      high_ctrl_q <= pwdata_in[7:0] & 8'h83;
    end else if (instr_tick && (low_power_sleep_enable_age_q == 2'(SLEEP_ENABLE_LIFE_INSTR - 1))) begin
      high_ctrl_q[POS_LOW_POWER_SLEEP_ENABLE] <= 1'b0;
    end
  end

  // Low control register; brown-out status and release survive the wake reset.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_ctrl_q <= RST_CONTROL;
    end else begin
      if (wake_por) begin
        low_ctrl_q[POS_SLOW_DISCHARGE_WAKE_DISABLE] <= 1'b0;
      end else if (wr_en && (idx == IDX_SLEEP_LOW_CONTROL)) begin
        low_ctrl_q <= pwdata_in[7:0] & 8'h07;
      end
      if (enter_deep) begin
        low_ctrl_q[POS_PIN_RELEASE] <= 1'b1;
        low_ctrl_q[POS_SLEEP_BROWNOUT_EVENT] <= 1'b0;
      end else if (state_q == ST_ASLEEP) begin
        if (bor_trip || (mclr_wake && !logged_q)) begin
          low_ctrl_q[POS_PIN_RELEASE] <= 1'b0;
        end
        if (bor_trip) begin
          low_ctrl_q[POS_SLEEP_BROWNOUT_EVENT] <= 1'b0;
        end else if (config_q[POS_BROWNOUT_ENABLE] && sync2_q[SY_ARM_LOW]) begin
          low_ctrl_q[POS_SLEEP_BROWNOUT_EVENT] <= 1'b1;
        end
      end
    end
  end

  // Pin state captured at entry and held until release clears.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      held_dir_q <= '1;
      held_level_q <= '0;
    end else if (enter_deep) begin
      held_dir_q <= pin_direction_bits_in;
      held_level_q <= pin_output_level_bits_in;
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_level_out <= '0;
      pin_oe_n_out <= '1;
    end else if (low_ctrl_q[POS_PIN_RELEASE] || enter_deep) begin
      pin_level_out <= enter_deep ? pin_output_level_bits_in : held_level_q;
      pin_oe_n_out <= enter_deep ? pin_direction_bits_in : held_dir_q;
    end else begin
      pin_level_out <= pin_output_level_bits_in;
      pin_oe_n_out <= pin_direction_bits_in;
    end
  end

  // Persistent scratch; only a supply loss or brown-out wipes it.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scratch_q <= RST_SCRATCH;
    end else if (((state_q != ST_ASLEEP) && sync2_q[SY_CORE_BOR])
                 || ((state_q == ST_ASLEEP) && bor_trip)) begin
      scratch_q <= RST_SCRATCH;
    end else if (wr_en && (idx == IDX_PERSISTENT_SCRATCH_ZERO)) begin
      scratch_q <= pwdata_in[7:0];
    end
  end

  // Wake status: cleared on entry, first source only.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_low_q <= RST_WAKE_STATUS_LOW;
      wake_high_q <= 1'b0;
      logged_q <= 1'b0;
    end else if (enter_deep) begin
      wake_low_q <= 8'h00;
      wake_high_q <= 1'b0;
      logged_q <= 1'b0;
    end else if (leave_sleep && !logged_q) begin
      logged_q <= 1'b1;
      if (fault_wake) begin
        wake_low_q[POS_FAULT] <= 1'b1;
      end else if (mclr_wake) begin
        wake_low_q[POS_MCLR_WAKE] <= 1'b1;
      end else if (bor_trip) begin
        wake_low_q[POS_POWER_ON] <= 1'b1;
      end else if (cal_wake) begin
        wake_low_q[POS_CALENDAR_WAKE] <= 1'b1;
      end else if (wdt_timeout) begin
        wake_low_q[POS_WATCHDOG_WAKE] <= 1'b1;
      end else if (slow_wake) begin
        wake_low_q[POS_SLOW_WAKE] <= 1'b1;
      end else begin
        wake_high_q <= 1'b1;
      end
    end else if (wr_en && (idx == IDX_WAKE_STATUS_LOW)) begin
      wake_low_q <= pwdata_in[7:0] & 8'hBD;
    end else if (wr_en && (idx == IDX_WAKE_STATUS_HIGH)) begin
      wake_high_q <= pwdata_in[POS_EXT_INT_WAKE];
    end
  end

  // Watchdog control register; the exit flag is set by hardware and wins over a clear.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wdt_ctrl_q <= RST_CONTROL;
    end else begin
      if (wr_en && (idx == IDX_WATCHDOG_CONTROL_REG)) begin
        wdt_ctrl_q <= pwdata_in[7:0] & 8'h88;
      end else if (wake_por) begin
        wdt_ctrl_q[POS_REGULATOR_SLEEP] <= 1'b0;
      end
      if (wake_por) begin
        wdt_ctrl_q[POS_SLEEP_EXIT_FLAG] <= 1'b1;
      end
    end
  end

  // Configuration bytes; only first power-up resets them.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      config_q <= RST_SLEEP_CONFIG;
      config3_q <= RST_SLEEP_CONFIG;
    end else if (wr_en && (idx == IDX_SLEEP_CONFIG)) begin
      config_q <= pwdata_in[7:0] & 8'h7F;
    end else if (wr_en && (idx == IDX_THIRD_CONFIG_LOW_BYTE)) begin
      config3_q <= pwdata_in[7:0] & 8'h02;
    end
  end
endmodule : deep_sleep_controller
`default_nettype wire

/* deep_sleep_assertions.sv */
// Port-level checker for the deep sleep controller.
`timescale 1ns/10ps
`default_nettype none
module deep_sleep_assertions
  import deep_sleep_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic sleep_instr_in,
  input wire logic mclr_n_in,
  input wire logic sleep_fault_in,
  input wire logic pslverr_out,
  input wire logic regulator_off_out,
  input wire logic conventional_sleep_out,
  input wire logic core_reset_out,
  input wire logic slow_discharge_module_on_out,
  input wire logic [PIN_COUNT-1:0] pin_oe_n_out,
  input wire logic [PIN_COUNT-1:0] pin_level_out
);
  // Counts the cycles of the wake reset hold; a shift-style repetition would be far too long.
  logic [8:0] hold_q;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hold_q <= 9'h000;
    end else begin
      hold_q <= core_reset_out ? hold_q + 9'h001 : 9'h000;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_hold_length: assert property ($fell(core_reset_out) |-> hold_q == POR_HOLD_CYC)
    else $error("wake reset hold has the wrong length");
  a_wake_from_sleep: assert property ($rose(core_reset_out) |-> $past(regulator_off_out))
    else $error("wake reset without deep sleep");
  a_fault_wakes: assert property (regulator_off_out && sleep_fault_in |-> ##[1:5] core_reset_out)
    else $error("fault did not wake the device");
  a_mclr_wakes: assert property (regulator_off_out && !mclr_n_in |-> ##[1:5] core_reset_out)
    else $error("master clear did not wake the device");
  a_sleep_choice: assert property (sleep_instr_in && !regulator_off_out && !core_reset_out
    |=> regulator_off_out != $past(conventional_sleep_out))
    else $error("sleep instruction chose no mode or both");
  a_conv_cause: assert property (conventional_sleep_out |-> sleep_instr_in && !regulator_off_out)
    else $error("conventional sleep without instruction");
  a_module_asleep: assert property (slow_discharge_module_on_out |-> regulator_off_out)
    else $error("slow discharge module on outside sleep");
  a_pins_held: assert property (regulator_off_out && $past(regulator_off_out) && $past(regulator_off_out, 2)
    |-> $stable(pin_oe_n_out) && $stable(pin_level_out))
    else $error("pins moved during sleep");
  a_err_in_access: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("error response outside access phase");
  c_deep_entry: cover property ($rose(regulator_off_out));
  c_conv_sleep: cover property (conventional_sleep_out);
  c_bus_error: cover property (pslverr_out);
endmodule : deep_sleep_assertions
bind deep_sleep_controller deep_sleep_assertions #(.PIN_COUNT(PIN_COUNT)) u_deep_sleep_assertions (
  .sys_clk_in, .sys_rst_in, .psel_in, .penable_in, .sleep_instr_in, .mclr_n_in, .sleep_fault_in,
  .pslverr_out, .regulator_off_out, .conventional_sleep_out, .core_reset_out,
  .slow_discharge_module_on_out, .pin_oe_n_out, .pin_level_out);
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the deep sleep controller.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import deep_sleep_pkg::*;
  logic sys_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic sleep_instr_in, mclr_n_in, calendar_alarm_in, ext_int_in, slow_discharge_wake_in;
  logic sleep_fault_in, supply_below_arm_in, supply_below_trip_in, core_brownout_in;
  logic internal_rc_oscillator_in, secondary_timer_oscillator_in, regulator_off_out;
  logic conventional_sleep_out, core_reset_out, slow_discharge_module_on_out, calendar_tick_out;
  logic [15:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, r;
  logic [7:0] pin_direction_bits_in, pin_output_level_bits_in, pin_level_out, pin_oe_n_out;
  logic [3:0] div = 4'h0;
  logic e;
  int bad_count, n_checks, cyc = 0, n;
  deep_sleep_controller #(.PIN_COUNT(8)) u_deep_sleep_controller (
    .sys_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .sleep_instr_in, .pin_direction_bits_in,
    .pin_output_level_bits_in, .mclr_n_in, .calendar_alarm_in, .ext_int_in,
    .slow_discharge_wake_in, .sleep_fault_in, .supply_below_arm_in, .supply_below_trip_in,
    .core_brownout_in, .internal_rc_oscillator_in, .secondary_timer_oscillator_in,
    .pin_level_out, .pin_oe_n_out, .regulator_off_out, .conventional_sleep_out,
    .core_reset_out, .slow_discharge_module_on_out, .calendar_tick_out);
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Slow oscillators: the RC one at a sixteenth and the timer at an eighth of the clock.
  assign internal_rc_oscillator_in = div[3];
  assign secondary_timer_oscillator_in = div[2];
  always @(posedge sys_clk_in) begin
    div <= div + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task give_verdict();
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    @(posedge sys_clk_in);
    while (pready_out !== 1'b1) @(posedge sys_clk_in);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  // Enable bit lives only two instruction cycles, so the instruction follows the write at once.
  task nap(input logic [7:0] hc);
    apb(1'b1, 16'h3D40, 32'h80);
    apb(1'b1, 16'h3D34, {24'h0, hc});
    sleep_instr_in <= 1'b1;
    @(posedge sys_clk_in);
    sleep_instr_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
  endtask : nap
  // Any 64-cycle window holds exactly 64/period oscillator rises, whatever the phase.
  task ticks(input int exp);
    n = 0;
    repeat (64) begin
      @(posedge sys_clk_in);
      n += (calendar_tick_out === 1'b1);
    end
    chk(n, exp);
  endtask : ticks
  task wake();
    while (core_reset_out !== 1'b1) @(posedge sys_clk_in);
    while (core_reset_out !== 1'b0) @(posedge sys_clk_in);
    repeat (2) @(posedge sys_clk_in);
  endtask : wake
  initial begin
    {psel_in, penable_in, pwrite_in, sleep_instr_in, calendar_alarm_in, ext_int_in} = '0;
    {slow_discharge_wake_in, sleep_fault_in, supply_below_arm_in, supply_below_trip_in} = '0;
    core_brownout_in = 1'b0;
    mclr_n_in = 1'b1;
    paddr_in = 16'h0;
    pwdata_in = 32'h0;
    pin_direction_bits_in = 8'h0F;
    pin_output_level_bits_in = 8'hA5;
    {bad_count, n_checks} = '0;
    sys_rst_in = 1'b1;
    repeat (10) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(16'h3D28, 32'h01);
    rd(16'h3D30, 32'h00);
    rd(16'h3D34, 32'h00);
    apb(1'b0, 16'h3D3C, 32'h0);
    chk(r, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 16'h3D39, 32'hFF);
    chk(e, 1'b1);
    apb(1'b1, 16'h3D38, 32'h5A);
    rd(16'h3D38, 32'h5A);
    apb(1'b1, 16'h3D34, 32'h80);
    repeat (10) @(posedge sys_clk_in);
    rd(16'h3D34, 32'h00);
    sleep_instr_in <= 1'b1;
    @(posedge sys_clk_in);
    chk(conventional_sleep_out, 1'b1);
    sleep_instr_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk(regulator_off_out, 1'b0);
    chk({pin_oe_n_out, pin_level_out & 8'hF0}, 16'h0FA0);
    ticks(4);
    nap(8'h80);
    chk(regulator_off_out, 1'b1);
    pin_direction_bits_in <= 8'hF0;
    pin_output_level_bits_in <= 8'h3C;
    sleep_fault_in <= 1'b1;
    wake();
    sleep_fault_in <= 1'b0;
    rd(16'h3D28, 32'h80);
    rd(16'h3D40, 32'h08);
    rd(16'h3D38, 32'h5A);
    chk({pin_oe_n_out, pin_level_out & 8'hF0}, 16'h0FA0);
    rd(16'h3D30, 32'h01);
    apb(1'b1, 16'h3D30, 32'h00);
    repeat (2) @(posedge sys_clk_in);
    chk({pin_oe_n_out, pin_level_out & 8'h0F}, 16'hF00C);
    apb(1'b1, 16'h3D40, 32'h00);
    rd(16'h3D40, 32'h00);
    apb(1'b1, 16'h3D44, 32'h40);
    apb(1'b1, 16'h3D48, 32'h02);
    nap(8'h81);
    calendar_alarm_in <= 1'b1;
    ticks(8);
    chk(regulator_off_out, 1'b1);
    supply_below_arm_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    supply_below_arm_in <= 1'b0;
    ext_int_in <= 1'b1;
    wake();
    {ext_int_in, calendar_alarm_in} <= 2'b00;
    rd(16'h3D28, 32'h00);
    rd(16'h3D2C, 32'h01);
    rd(16'h3D30, 32'h03);
    apb(1'b1, 16'h3D30, 32'h00);
    apb(1'b1, 16'h3D44, 32'h03);
    nap(8'h80);
    n = 0;
    while (core_reset_out !== 1'b1) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk(n > 400 && n < 700, 1'b1);
    wake();
    rd(16'h3D28, 32'h10);
    apb(1'b1, 16'h3D44, 32'h00);
    apb(1'b1, 16'h3D30, 32'h04);
    nap(8'h82);
    chk(slow_discharge_module_on_out, 1'b1);
    {slow_discharge_wake_in, supply_below_trip_in} <= 2'b11;
    repeat (6) @(posedge sys_clk_in);
    chk(regulator_off_out, 1'b1);
    {slow_discharge_wake_in, supply_below_trip_in} <= 2'b00;
    mclr_n_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    mclr_n_in <= 1'b1;
    wake();
    rd(16'h3D28, 32'h04);
    rd(16'h3D30, 32'h00);
    rd(16'h3D34, 32'h00);
    rd(16'h3D38, 32'h5A);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
